// File: core/auc_uart.sv
// One asynchronous serial channel with APB registers.
// Assumes synchronous pin inputs and a 32-bit APB master.
//
// Added by the designer: register access over APB and the placing of the registers.
`timescale 1ns/1ns
module auc_uart
	import auc_pkg::*;
(
	input  wire logic        i_clock,
	input  wire logic        i_sys_rst,
	input  wire logic        i_psel,
	input  wire logic        i_penable,
	input  wire logic        i_pwrite,
	input  wire logic [7:0]  i_paddr,
	input  wire logic [31:0] i_pwdata,
	input  wire logic [3:0]  i_pstrb,
	output logic      [31:0] o_prdata,
	output logic             o_pready,
	output logic             o_pslverr,
	input  wire logic        i_serial_in,
	input  wire logic        i_serial_clock_pin,
	output logic             o_serial_out_pin_o,
	output logic             o_serial_out_pin_oe_n,
	output logic             o_tx_irq,
	output logic             o_rx_irq
);
	////////////////////////////////////////////////////////////////////
	logic [7:0]  brg_reg, mr_reg, c0_reg, c1_reg;
	logic [8:0]  tbuf_reg, rb_data_reg;
	logic        ti_reg, ri_reg, oer_reg, fer_reg, per_reg;
	logic        pready_reg, slverr_reg;
	logic [31:0] prdata_reg;
	logic [4:0]  pre_cnt_reg;
	logic [7:0]  brg_cnt_reg;
	logic        clk_d_reg, rx_d_reg;
	auc_state_t  tx_state_reg, tx_state_next, rx_state_reg;
	logic [3:0]  tx_ovs_reg, tx_bit_reg, rx_ovs_reg, rx_bit_reg;
	logic [8:0]  tx_shift_reg, rx_shift_reg;
	logic        tx_par_reg, tx_stop2_reg, rx_stop2_reg;
	logic        rx_ovr_reg, rx_fer_reg, rx_per_reg;
	logic        pin_o_reg, pin_oe_n_reg, tx_irq_reg, rx_irq_reg;

	// Bus decode
	wire acc     = i_psel & i_penable;
	wire fin     = acc & pready_reg;
	wire wr      = fin & i_pwrite;
	wire rd      = fin & ~i_pwrite;
	wire sel_tb  = i_paddr == ADDR_TB;
	wire sel_rb  = i_paddr == ADDR_RB;
	wire sel_brg = i_paddr == ADDR_BRG;
	wire sel_mr  = i_paddr == ADDR_MR;
	wire sel_c0  = i_paddr == ADDR_C0;
	wire sel_c1  = i_paddr == ADDR_C1;
	wire mapped  = sel_tb | sel_rb | sel_brg | sel_mr | sel_c0 | sel_c1;
	wire wr_tbl  = wr & sel_tb & i_pstrb[0];
	wire wr_tbh  = wr & sel_tb & i_pstrb[1];
	wire rd_rb   = rd & sel_rb;

	// Mode fields
	wire [2:0] smd   = mr_reg[2:0];
	wire uart_mode   = smd == SMD_7 || smd == SMD_8 || smd == SMD_9;
	wire stop_length_sel        = mr_reg[MR_STOP_LENGTH_SEL];
	wire odd_par     = mr_reg[MR_PRY];
	wire par_en      = mr_reg[MR_PARITY_ENABLE_BIT];
	wire open_drain_sel         = c0_reg[C0_NCH];
	wire clock_polarity_sel       = c0_reg[C0_CLOCK_POLARITY_SEL];
	wire te          = c1_reg[C1_TE];
	wire re          = c1_reg[C1_RE];
	wire irs         = c1_reg[C1_IRS];
	wire rrm         = c1_reg[C1_RRM];
	// Order select only counts at eight bits
	wire msb_first   = c0_reg[C0_BIT_ORDER_SEL] && smd == SMD_8;
	// Character length and its mask
	wire [3:0] nbits = smd == SMD_7 ? 4'h7 :
		smd == SMD_9 ? 4'h9 : 4'h8;
	wire [8:0] dmask = smd == SMD_7 ? 9'h07f :
		smd == SMD_9 ? 9'h1ff : 9'h0ff;
	wire [3:0] last_bit = nbits - 4'h1;

	// Status and read mux
	wire tx_shift_empty_flag = tx_state_reg == ST_IDLE;
	wire sum   = oer_reg | fer_reg | per_reg;
	wire [31:0] rb_word = {16'h0000, sum, per_reg, fer_reg, oer_reg,
		3'h0, rb_data_reg};
	wire [7:0] c0_rd = {c0_reg[7:4], tx_shift_empty_flag, c0_reg[2:0]};
	wire [7:0] c1_rd = {c1_reg[7:4], ri_reg, c1_reg[2], ti_reg, c1_reg[0]};
	wire [31:0] rd_mux = sel_rb ? rb_word :
		sel_brg ? {24'h000000, brg_reg} :
		sel_mr  ? {24'h000000, mr_reg} :
		sel_c0  ? {24'h000000, c0_rd} :
		sel_c1  ? {24'h000000, c1_rd} : 32'h00000000;

	////////////////////////////////////////////////////////////////////
	// APB answer one cycle into the access phase
	always_ff @(posedge i_clock or posedge i_sys_rst)
	begin
		if (i_sys_rst)
		begin
			pready_reg <= 1'b0;
			slverr_reg <= 1'b0;
			prdata_reg <= 32'h00000000;
		end
		else
		begin
			pready_reg <= acc & ~pready_reg;
			slverr_reg <= acc & ~pready_reg & ~mapped;
			prdata_reg <= (acc & ~pready_reg & ~i_pwrite) ? rd_mux
				: 32'h00000000;
		end
	end

	// Plain control registers; status bits are merged on read
	always_ff @(posedge i_clock or posedge i_sys_rst)
	begin
		if (i_sys_rst)
		begin
			brg_reg <= REG_RST;
			mr_reg  <= REG_RST;
			c0_reg  <= REG_RST;
			c1_reg  <= REG_RST;
		end
		else if (wr & i_pstrb[0])
		begin
			if (sel_brg)
				brg_reg <= i_pwdata[7:0];
			if (sel_mr)
				mr_reg <= i_pwdata[7:0];
			if (sel_c0)
				c0_reg <= i_pwdata[7:0];
			if (sel_c1)
				c1_reg <= i_pwdata[7:0];
		end
	end

	////////////////////////////////////////////////////////////////////
	// Prescaler and divider produce the 16x tick
	wire pre_tick = c0_reg[1:0] == SRC_F8 ? pre_cnt_reg[2:0] ==
		PRE_LIM8[2:0] : c0_reg[1:0] == SRC_F32 ?
		pre_cnt_reg == PRE_LIM32 : 1'b1;
	// Pin edge chosen by polarity: rising for 0, falling for 1
	wire ext_edge = clock_polarity_sel ? (clk_d_reg & ~i_serial_clock_pin) :
		(~clk_d_reg & i_serial_clock_pin);
	wire brg_src = mr_reg[MR_CLOCK_SOURCE_DIR] ? ext_edge : pre_tick;
	wire os_tick = brg_src && brg_cnt_reg == 8'h00;

	always_ff @(posedge i_clock or posedge i_sys_rst)
	begin
		if (i_sys_rst)
		begin
			pre_cnt_reg <= 5'h00;
			brg_cnt_reg <= 8'h00;
			clk_d_reg   <= 1'b0;
			rx_d_reg    <= 1'b1;
		end
		else
		begin
			pre_cnt_reg <= pre_cnt_reg + 5'h01;
			clk_d_reg   <= i_serial_clock_pin;
			rx_d_reg    <= i_serial_in;
			// Divide by value plus one
			if (brg_src)
				brg_cnt_reg <= os_tick ? brg_reg
					: brg_cnt_reg - 8'h01;
		end
	end

	////////////////////////////////////////////////////////////////////
	// Transmitter
	// Explicit bit swap keeps the select a plain concatenation
	wire [8:0] tb_load = msb_first ? {1'b0, tbuf_reg[0], tbuf_reg[1],
		tbuf_reg[2], tbuf_reg[3], tbuf_reg[4], tbuf_reg[5],
		tbuf_reg[6], tbuf_reg[7]} : tbuf_reg;
	wire tx_go  = tx_state_reg == ST_IDLE && te && !ti_reg
		&& uart_mode && os_tick;
	wire tx_end = os_tick && tx_ovs_reg == OVS_LAST;
	wire tx_fin = tx_end && tx_state_reg == ST_STOP
		&& (!stop_length_sel || tx_stop2_reg);

	// Next state of the frame sequence
	always_comb
	begin
		tx_state_next = tx_state_reg;
		case (tx_state_reg)
			ST_IDLE:
				if (tx_go)
					tx_state_next = ST_START;
			ST_START:
				if (tx_end)
					tx_state_next = ST_DATA;
			ST_DATA:
				if (tx_end && tx_bit_reg == last_bit)
					tx_state_next = par_en ? ST_PAR : ST_STOP;
			ST_PAR:
				if (tx_end)
					tx_state_next = ST_STOP;
			ST_STOP:
				if (tx_fin)
					tx_state_next = ST_IDLE;
			default:
				tx_state_next = ST_IDLE;
		endcase
	end

	// Line level of the current bit
	wire tx_level = tx_state_reg == ST_START ? 1'b0 :
		tx_state_reg == ST_DATA ? tx_shift_reg[0] :
		tx_state_reg == ST_PAR ? tx_par_reg : 1'b1;

	always_ff @(posedge i_clock or posedge i_sys_rst)
	begin
		if (i_sys_rst)
		begin
			tx_state_reg <= ST_IDLE;
			tx_ovs_reg   <= 4'h0;
			tx_bit_reg   <= 4'h0;
			tx_shift_reg <= 9'h000;
			tx_par_reg   <= 1'b0;
			tx_stop2_reg <= 1'b0;
		end
		else
		begin
			tx_state_reg <= tx_state_next;
			if (tx_go)
			begin
				tx_ovs_reg   <= 4'h0;
				tx_bit_reg   <= 4'h0;
				tx_stop2_reg <= 1'b0;
				tx_shift_reg <= tb_load;
				// Odd sense adds a one to an even count
				tx_par_reg <= ^(tbuf_reg & dmask) ^ odd_par;
			end
			else if (os_tick)
				tx_ovs_reg <= tx_ovs_reg + 4'h1;
			if (tx_end && tx_state_reg == ST_DATA)
			begin
				tx_shift_reg <= {1'b0, tx_shift_reg[8:1]};
				tx_bit_reg   <= tx_bit_reg + 4'h1;
			end
			if (tx_end && tx_state_reg == ST_STOP)
				tx_stop2_reg <= 1'b1;
		end
	end

	// Pin drive; open drain only ever pulls low
	always_ff @(posedge i_clock or posedge i_sys_rst)
	begin
		if (i_sys_rst)
		begin
			pin_o_reg    <= 1'b1;
			pin_oe_n_reg <= 1'b0;
		end
		else if (open_drain_sel)
		begin
			pin_o_reg    <= 1'b0;
			pin_oe_n_reg <= tx_level | ~uart_mode;
		end
		else
		begin
			pin_o_reg    <= tx_level | ~uart_mode;
			pin_oe_n_reg <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////
	// Receiver, mid-bit sampling on the 16x tick
	wire rx_mid  = os_tick && rx_ovs_reg == OVS_MID;
	wire rx_end  = os_tick && rx_ovs_reg == OVS_LAST;
	wire rx_go   = rx_state_reg == ST_IDLE && re && uart_mode
		&& rx_d_reg && !i_serial_in;
	wire [8:0] rx_word = (rx_shift_reg >> (4'h9 - nbits)) & dmask;
	wire [8:0] rx_data = msb_first ? {1'b0, rx_word[0], rx_word[1],
		rx_word[2], rx_word[3], rx_word[4], rx_word[5],
		rx_word[6], rx_word[7]} : rx_word;
	wire rx_final = !stop_length_sel || rx_stop2_reg;
	// Bit just ahead of the final stop bit
	wire pre_stop = (rx_state_reg == ST_DATA && rx_bit_reg == last_bit
		&& !par_en && !stop_length_sel) || (rx_state_reg == ST_PAR && !stop_length_sel)
		|| (rx_state_reg == ST_STOP && stop_length_sel && !rx_stop2_reg);
	wire ovr_now  = rx_mid && pre_stop && ri_reg;
	wire rx_done  = rx_mid && rx_state_reg == ST_STOP && rx_final;
	wire rx_ovr   = rx_ovr_reg | ovr_now;
	wire stop_bad = !i_serial_in;

	always_ff @(posedge i_clock or posedge i_sys_rst)
	begin
		if (i_sys_rst)
		begin
			rx_state_reg <= ST_IDLE;
			rx_ovs_reg   <= 4'h0;
			rx_bit_reg   <= 4'h0;
			rx_shift_reg <= 9'h000;
			rx_stop2_reg <= 1'b0;
			rx_ovr_reg   <= 1'b0;
			rx_fer_reg   <= 1'b0;
			rx_per_reg   <= 1'b0;
		end
		else
		begin
			if (os_tick)
				rx_ovs_reg <= rx_ovs_reg + 4'h1;
			if (ovr_now)
				rx_ovr_reg <= 1'b1;
			case (rx_state_reg)
				ST_IDLE:
					if (rx_go)
					begin
						rx_state_reg <= ST_START;
						rx_ovs_reg   <= 4'h0;
						rx_bit_reg   <= 4'h0;
						rx_stop2_reg <= 1'b0;
						rx_ovr_reg   <= 1'b0;
						rx_fer_reg   <= 1'b0;
						rx_per_reg   <= 1'b0;
					end
				ST_START:
					// A glitch that is high at mid-bit is no start
					if (rx_mid && i_serial_in)
						rx_state_reg <= ST_IDLE;
					else if (rx_end)
						rx_state_reg <= ST_DATA;
				ST_DATA:
				begin
					if (rx_mid)
						rx_shift_reg <= {i_serial_in, rx_shift_reg[8:1]};
					if (rx_end)
					begin
						rx_bit_reg <= rx_bit_reg + 4'h1;
						if (rx_bit_reg == last_bit)
							rx_state_reg <= par_en ? ST_PAR : ST_STOP;
					end
				end
				ST_PAR:
				begin
					if (rx_mid)
						rx_per_reg <= ^rx_word ^ i_serial_in
							^ odd_par;
					if (rx_end)
						rx_state_reg <= ST_STOP;
				end
				ST_STOP:
				begin
					if (rx_mid && stop_bad)
						rx_fer_reg <= 1'b1;
					if (rx_done)
						rx_state_reg <= ST_IDLE;
					else if (rx_end)
						rx_stop2_reg <= 1'b1;
				end
				default:
					rx_state_reg <= ST_IDLE;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////
	// Buffers and flags; receive set wins over a read clear, but a read clear of ti wins over the load
	always_ff @(posedge i_clock or posedge i_sys_rst)
	begin
		if (i_sys_rst)
		begin
			tbuf_reg    <= 9'h000;
			rb_data_reg <= 9'h000;
			ti_reg      <= 1'b1;
			ri_reg      <= 1'b0;
			oer_reg     <= 1'b0;
			fer_reg     <= 1'b0;
			per_reg     <= 1'b0;
		end
		else
		begin
			if (wr_tbl)
				tbuf_reg[7:0] <= i_pwdata[7:0];
			if (wr_tbh)
				tbuf_reg[8] <= i_pwdata[8];
			// A fresh write beats the load so no character is lost
			if (wr_tbl || (rd_rb && rrm))
				ti_reg <= 1'b0;
			else if (tx_go)
				ti_reg <= 1'b1;
			if (rx_done && rx_ovr)
				oer_reg <= 1'b1;
			else if (!re)
				oer_reg <= 1'b0;
			if (rx_done && !rx_ovr)
			begin
				rb_data_reg <= rx_data;
				ri_reg      <= 1'b1;
				fer_reg     <= rx_fer_reg | stop_bad;
				per_reg     <= rx_per_reg;
			end
			else if (rd_rb)
			begin
				ri_reg  <= 1'b0;
				fer_reg <= 1'b0;
				per_reg <= 1'b0;
			end
		end
	end

	// Request pulses; overrun raises none
	always_ff @(posedge i_clock or posedge i_sys_rst)
	begin
		if (i_sys_rst)
		begin
			tx_irq_reg <= 1'b0;
			rx_irq_reg <= 1'b0;
		end
		else
		begin
			tx_irq_reg <= (tx_go && !irs) || (tx_fin && irs);
			rx_irq_reg <= rx_done && !rx_ovr;
		end
	end

	assign o_prdata              = prdata_reg;
	assign o_pready              = pready_reg;
	assign o_pslverr             = slverr_reg;
	assign o_serial_out_pin_o    = pin_o_reg;
	assign o_serial_out_pin_oe_n = pin_oe_n_reg;
	assign o_tx_irq              = tx_irq_reg;
	assign o_rx_irq              = rx_irq_reg;

	////////////////////////////////////////////////////////////////////
	// Checks
	default clocking cb @(posedge i_clock); endclocking
	default disable iff (i_sys_rst);

	a_tx_start_cond: assert property (
		tx_state_reg == ST_IDLE ##1 tx_state_reg == ST_START
		|-> $past(te) && !$past(ti_reg) && ti_reg)
		else $error("transmit started without enable or data");
	a_tx_irq_load: assert property (
		tx_go && !irs |=> o_tx_irq && tx_state_reg == ST_START)
		else $error("no transmit request at load");
	a_tx_irq_end: assert property (
		tx_fin && irs |=> o_tx_irq && tx_shift_empty_flag)
		else $error("no transmit request at frame end");
	a_rx_start_en: assert property (
		rx_state_reg == ST_IDLE ##1 rx_state_reg == ST_START
		|-> $past(re) && $past(rx_d_reg) && !$past(i_serial_in))
		else $error("reception began without enable or start");
	a_rx_irq_ri: assert property (
		o_rx_irq |-> ri_reg && $past(rx_done))
		else $error("receive request without completion");
	a_rrm_clear_ti: assert property (
		rd_rb && rrm |=> !ti_reg)
		else $error("continuous read left buffer-empty set");
	a_rb_read_clr: assert property (
		rd_rb && !rx_done |=> !ri_reg && !fer_reg && !per_reg)
		else $error("buffer read did not clear flags");
	a_ovr_no_irq: assert property (
		rx_done && rx_ovr |=> oer_reg && !o_rx_irq
		&& $stable(rb_data_reg))
		else $error("overrun mishandled");
	a_idle_high: assert property (
		(tx_shift_empty_flag && uart_mode && !open_drain_sel)[*2] |-> o_serial_out_pin_o
		&& !o_serial_out_pin_oe_n)
		else $error("idle line not high");

	c_tx_frame: cover property (tx_go ##1 tx_state_reg == ST_START);
	c_tx_done:  cover property (tx_fin && irs);
	c_rx_frame: cover property (rx_done && !rx_ovr);
	c_overrun:  cover property ($rose(oer_reg));
endmodule

// File: core/auc_pkg.sv
// Constants shared by the asynchronous serial channel.
// Assumes a 32-bit APB master and one system clock.
package auc_pkg;
	// Register byte addresses
	localparam logic [7:0] ADDR_TB  = 8'h00;
	localparam logic [7:0] ADDR_RB  = 8'h04;
	localparam logic [7:0] ADDR_BRG = 8'h08;
	localparam logic [7:0] ADDR_MR  = 8'h0c;
	localparam logic [7:0] ADDR_C0  = 8'h10;
	localparam logic [7:0] ADDR_C1  = 8'h14;
	// Mode control fields
	localparam int MR_CLOCK_SOURCE_DIR = 3;
	localparam int MR_STOP_LENGTH_SEL  = 4;
	localparam int MR_PRY   = 5;
	localparam int MR_PARITY_ENABLE_BIT  = 6;
	// Control zero fields
	localparam int C0_TX_SHIFT_EMPTY_FLAG = 3;
	localparam int C0_NCH   = 5;
	localparam int C0_CLOCK_POLARITY_SEL = 6;
	localparam int C0_BIT_ORDER_SEL = 7;
	// Control one fields
	localparam int C1_TE  = 0;
	localparam int C1_TI  = 1;
	localparam int C1_RE  = 2;
	localparam int C1_RI  = 3;
	localparam int C1_IRS = 4;
	localparam int C1_RRM = 5;
	// Receive buffer flag positions
	localparam int RB_OER = 12;
	localparam int RB_FER = 13;
	localparam int RB_PER = 14;
	localparam int RB_SUM = 15;
	// Serial mode field values
	localparam logic [2:0] SMD_7 = 3'h4;
	localparam logic [2:0] SMD_8 = 3'h5;
	localparam logic [2:0] SMD_9 = 3'h6;
	// Prescaler source select and limits
	localparam logic [1:0] SRC_F8  = 2'h1;
	localparam logic [1:0] SRC_F32 = 2'h2;
	localparam logic [4:0] PRE_LIM8  = 5'h07;
	localparam logic [4:0] PRE_LIM32 = 5'h1f;
	// Sixteen-times oversampling points
	localparam logic [3:0] OVS_MID  = 4'h7;
	localparam logic [3:0] OVS_LAST = 4'hf;
	// Reset values
	localparam logic [7:0] REG_RST = 8'h00;
	// Shared frame state, one bit changing per step from idle through parity to stop
	typedef enum logic [2:0] {
		ST_IDLE  = 3'b000,
		ST_START = 3'b001,
		ST_DATA  = 3'b011,
		ST_PAR   = 3'b010,
		ST_STOP  = 3'b110
	} auc_state_t;
endpackage

// File: test/auc_remote.sv
// Remote serial transceiver model facing the channel's line pins.
// Assumes the caller gives bit times in system clock cycles.
`timescale 1ns/1ns
module auc_remote
(
	input  wire logic i_clock,
	input  wire logic i_line,
	output logic      o_line
);
	////////////////////////////////////////////////////////////////////////
	// Line rests at mark level between frames
	initial
		o_line = 1'b1;

	// Drive one frame, bit 0 of the vector first
	task automatic send(input logic [12:0] f, input int len,
		input int cpb);
		for (int i = 0; i < len; i++)
		begin
			o_line <= f[i];
			repeat (cpb) @(posedge i_clock);
		end
		o_line <= 1'b1;
		// One mark cycle so that back-to-back frames never merge
		@(posedge i_clock);
	endtask

	// Catch one frame, sampling each bit at its centre
	task automatic recv(input int len, input int cpb,
		output logic [12:0] f);
		f = '0;
		for (int n = 0; n < 40000 && i_line !== 1'b0; n++)
			@(posedge i_clock);
		repeat (cpb / 2) @(posedge i_clock);
		for (int i = 0; i < len; i++)
		begin
			f[i] = i_line;
			if (i < len - 1)
				repeat (cpb) @(posedge i_clock);
		end
	endtask
endmodule

// File: test/auc_uart_tb.sv
// Self-checking bench for the asynchronous serial channel.
// Assumes the remote line model; APB master and clocks are made here.
`timescale 1ns/1ns
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin fails++; \
$display("wrong value at %0t: got %h expected %h", $time, a, b); end end
module auc_uart_tb import auc_pkg::*;;
	logic        clock = 1'b0;
	logic        sys_rst = 1'b1;
	logic        psel = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite = 1'b0;
	logic [7:0]  paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic [3:0]  pstrb = 4'h0;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic        rx_line;
	logic        pin_o;
	logic        oe_n;
	logic        tx_irq;
	logic        rx_irq;
	logic        line;
	logic [1:0]  ecnt = 2'h0;
	logic [31:0] rd;
	logic        perr;
	logic [12:0] fr;
	int          fails = 0;
	int          num_checks = 0;
	int          tx_cnt = 0;
	int          rx_cnt = 0;
	int          cyc = 0;
	int          ln;
	int          cp;
	int          r0;

	// Pull-up holds the released output line at mark
	assign line = (oe_n === 1'b1) ? 1'b1 : pin_o;

	auc_uart dut_u (
		.i_clock              (clock),
		.i_sys_rst            (sys_rst),
		.i_psel               (psel),
		.i_penable            (penable),
		.i_pwrite             (pwrite),
		.i_paddr              (paddr),
		.i_pwdata             (pwdata),
		.i_pstrb              (pstrb),
		.o_prdata             (prdata),
		.o_pready             (pready),
		.o_pslverr            (pslverr),
		.i_serial_in          (rx_line),
		.i_serial_clock_pin   (ecnt[1]),
		.o_serial_out_pin_o   (pin_o),
		.o_serial_out_pin_oe_n(oe_n),
		.o_tx_irq             (tx_irq),
		.o_rx_irq             (rx_irq)
	);

	auc_remote remote_u (
		.i_clock(clock),
		.i_line (line),
		.o_line (rx_line)
	);

	////////////////////////////////////////////////////////////////////////
	// 250 MHz system clock
	initial
		forever #2 clock = ~clock;

	// External clock of four cycles, pulse counters and hang limit
	always @(posedge clock)
	begin
		ecnt <= ecnt + 2'h1;
		cyc <= cyc + 1;
		if (tx_irq === 1'b1)
			tx_cnt <= tx_cnt + 1;
		if (rx_irq === 1'b1)
			rx_cnt <= rx_cnt + 1;
		if (cyc == 40000)
		begin
			fails++;
			stop_test();
		end
	end

	////////////////////////////////////////////////////////////////////////
	task automatic stop_test();
		$display("checks %0d mismatches %0d", num_checks, fails);
		if (fails == 0 && num_checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	// One APB transfer; called right after a rising edge
	task automatic apb(input logic w, input logic [7:0] a,
		input logic [31:0] wd, input logic [3:0] s);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= wd;
		pstrb <= s;
		@(posedge clock);
		penable <= 1'b1;
		do
			@(posedge clock);
		while (pready !== 1'b1);
		rd = prdata;
		perr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		// Idle edge so the next setup never lands in this time step
		@(posedge clock);
	endtask

	task automatic rdm(input logic [7:0] a);
		apb(1'b0, a, 32'h0, 4'h0);
	endtask

	task automatic cfg(input logic [7:0] mr, c0, brg, c1);
		apb(1'b1, ADDR_BRG, {24'h0, brg}, 4'h1);
		apb(1'b1, ADDR_C0, {24'h0, c0}, 4'h1);
		apb(1'b1, ADDR_MR, {24'h0, mr}, 4'h1);
		apb(1'b1, ADDR_C1, {24'h0, c1}, 4'h1);
	endtask

	// Expected line frame and bit time in clocks for a setting
	function automatic int build(input logic [7:0] mr, c0, brg,
		input logic [8:0] d, output logic [12:0] f, output int cpb);
		int nd;
		int n;
		logic [8:0] dm;
		nd = (mr[2:0] == SMD_7) ? 7 : (mr[2:0] == SMD_8) ? 8 : 9;
		dm = d & ((9'h001 << nd) - 9'h001);
		f = '0;
		for (int i = 0; i < nd; i++)
			f[1 + i] = (c0[7] && nd == 8) ? d[7 - i] : d[i];
		n = nd + 1;
		if (mr[6])
		begin
			f[n] = ^dm ^ mr[5];
			n++;
		end
		f[n] = 1'b1;
		f[n + 1] = mr[4];
		cpb = 16 * (int'(brg) + 1) * (mr[3] ? 4 :
			(c0[1:0] == SRC_F8) ? 8 : (c0[1:0] == SRC_F32) ? 32 : 1);
		return n + 1 + int'(mr[4]);
	endfunction

	task automatic tx_case(input logic [7:0] mr, c0, brg,
		input logic irs, input logic [8:0] d);
		logic [12:0] f;
		logic [12:0] got;
		int len;
		int cpb;
		int t0;
		len = build(mr, c0, brg, d, f, cpb);
		cfg(mr, c0, brg, {3'h0, irs, 4'h1});
		t0 = tx_cnt;
		// High byte first, so bit 8 is in place before the load
		apb(1'b1, ADDR_TB, {23'h0, d}, 4'h2);
		apb(1'b1, ADDR_TB, {23'h0, d}, 4'h1);
		remote_u.recv(len, cpb, got);
		`CHK(got, f)
		`CHK(tx_cnt - t0, irs ? 0 : 1)
		rdm(ADDR_C0);
		`CHK(rd[C0_TX_SHIFT_EMPTY_FLAG], 1'b0)
		repeat (cpb) @(posedge clock);
		`CHK(tx_cnt - t0, 1)
		rdm(ADDR_C0);
		`CHK(rd[C0_TX_SHIFT_EMPTY_FLAG], 1'b1)
		$display("tx test done");
	endtask

	// bad[0] flips parity, bad[1] breaks the last stop bit
	task automatic rx_case(input logic [7:0] mr, c0, brg,
		input logic [8:0] d, input logic [1:0] bad, input logic [3:0] fl);
		logic [12:0] f;
		logic [8:0] mk;
		int len;
		int cpb;
		int q0;
		len = build(mr, c0, brg, d, f, cpb);
		mk = (mr[2:0] == SMD_7) ? 9'h07f :
			(mr[2:0] == SMD_8) ? 9'h0ff : 9'h1ff;
		f[len - 2 - int'(mr[4])] ^= bad[0];
		f[len - 1] ^= bad[1];
		cfg(mr, c0, brg, 8'h04);
		q0 = rx_cnt;
		remote_u.send(f, len, cpb);
		`CHK(rx_cnt - q0, 1)
		rdm(ADDR_RB);
		`CHK(rd[8:0] & mk, d & mk)
		`CHK(rd[15:12], fl)
		rdm(ADDR_C1);
		`CHK(rd[C1_RI], 1'b0)
		$display("rx test done");
	endtask

	////////////////////////////////////////////////////////////////////////
	// Main sequence
	initial
	begin
		repeat (10) @(posedge clock);
		sys_rst <= 1'b0;
		@(posedge clock);
		`CHK(oe_n, 1'b0)
		`CHK(pin_o, 1'b1)
		rdm(ADDR_C1);
		`CHK(rd[7:0], 8'h02)
		rdm(ADDR_C0);
		`CHK(rd[7:0], 8'h08)
		apb(1'b1, 8'h18, 32'hffffffff, 4'hf);
		`CHK(perr, 1'b1)
		apb(1'b0, 8'h18, 32'h0, 4'h0);
		`CHK(rd, 32'h0)
		$display("register test done");
		tx_case(8'h04, 8'h20, 8'h00, 1'b0, 9'h055);
		`CHK(oe_n, 1'b1)
		tx_case(8'h55, 8'h00, 8'h00, 1'b1, 9'h0a7);
		tx_case(8'h66, 8'h00, 8'h00, 1'b0, 9'h1c3);
		tx_case(8'h05, 8'h80, 8'h00, 1'b0, 9'h0b1);
		tx_case(8'h05, 8'h01, 8'h01, 1'b0, 9'h03c);
		tx_case(8'h05, 8'h02, 8'h00, 1'b1, 9'h0c9);
		tx_case(8'h0d, 8'h00, 8'h02, 1'b0, 9'h05a);
		rx_case(8'h04, 8'h00, 8'h00, 9'h1ff, 2'h0, 4'h0);
		rx_case(8'h56, 8'h00, 8'h00, 9'h1a5, 2'h0, 4'h0);
		rx_case(8'h65, 8'h00, 8'h00, 9'h03c, 2'h1, 4'hc);
		rx_case(8'h05, 8'h00, 8'h00, 9'h0e1, 2'h2, 4'ha);
		rx_case(8'h05, 8'h80, 8'h00, 9'h0b1, 2'h0, 4'h0);
		rx_case(8'h0d, 8'h40, 8'h01, 9'h0c3, 2'h0, 4'h0);
		// Second frame arrives before the first is read
		ln = build(8'h05, 8'h00, 8'h00, 9'h033, fr, cp);
		cfg(8'h05, 8'h00, 8'h00, 8'h04);
		r0 = rx_cnt;
		remote_u.send(fr, ln, cp);
		remote_u.send(fr, ln, cp);
		`CHK(rx_cnt - r0, 1)
		rdm(ADDR_RB);
		`CHK(rd[15:12], 4'h9)
		// Short low glitch must not start a frame
		r0 = rx_cnt;
		remote_u.send(13'h0, 1, 4);
		repeat (32) @(posedge clock);
		`CHK(rx_cnt - r0, 0)
		// Receiver disabled clears overrun and ignores the line
		cfg(8'h05, 8'h00, 8'h00, 8'h00);
		remote_u.send(fr, ln, cp);
		`CHK(rx_cnt - r0, 0)
		rdm(ADDR_RB);
		`CHK(rd[RB_OER], 1'b0)
		$display("error test done");
		// Buffer read with rrm set clears ti; the line stays idle
		cfg(8'h05, 8'h00, 8'h00, 8'h20);
		rdm(ADDR_RB);
		rdm(ADDR_C1);
		`CHK(rd[C1_TI], 1'b0)
		repeat (64) @(posedge clock);
		`CHK(line, 1'b1)
		$display("continuous test done");
		stop_test();
	end
endmodule
